// >>> sic_top.sv
// Level-sensitive interrupt controller with a classic Wishbone register slave.
//
// What this block does
// RQ1 - Gathers twenty-two interrupt sources into the controller.
// RQ2 - Seventeen sources drive the normal request, five drive the fast request.
// RQ3 - The fast request outranks the normal request at the processor.
// RQ4 - No ordering among sources of one group; software picks the order.
// RQ5 - Every input is level sensitive and requests while held active.
// RQ6 - A source requests only while its mask bit is set.
// RQ7 - Status registers show which sources currently request service.
// RQ8 - Software clears each request at its own peripheral; latched ones also need a write to the latch clear register.
// RQ9 - End-of-interrupt sources are latched and stay pending once gone.
// RQ10 - Unlatched sources must stay active until their service routine starts.
// RQ11 - First pair bits 0-3: external fast, battery low, watchdog, media.
// RQ12 - First pair bits 4-7: codec sound, external inputs one to three.
// RQ13 - First pair bits 8-11: timer one, timer two, clock match, tick.
// RQ14 - First pair bits 12-15: uart one tx, rx, modem, serial one done.
// RQ15 - Second pair: key, serial two rx/tx, uart two tx/rx.
// RQ16 - Third pair bit 0: audio serial interrupt, fast group.
// RQ17 - Each request is the OR of masked sources; unused bits read zero.
// RQ18 - All mask bits reset to zero.
`timescale 1ns/1ps

module sic_top
    import sic_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rstn,
    // Wishbone slave.
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // External pins, active low except the third input.
    input wire logic i_external_fast_pin_n,
    input wire logic i_external_pin_one_n,
    input wire logic i_external_pin_two_n,
    input wire logic i_external_source_three,
    // Internal peripheral sources, active high.
    input wire logic i_battery_low_source,
    input wire logic i_watchdog_expired_source,
    input wire logic i_media_changed_source,
    input wire logic i_codec_sound_source,
    input wire logic i_timer_one_underflow,
    input wire logic i_timer_two_underflow,
    input wire logic i_clock_compare_match,
    input wire logic i_periodic_tick_source,
    input wire logic i_uart_one_tx_empty,
    input wire logic i_uart_one_rx_full,
    input wire logic i_uart_one_modem_change,
    input wire logic i_serial_one_transfer_done,
    input wire logic i_key_press_source,
    input wire logic i_serial_two_rx_block,
    input wire logic i_serial_two_tx_block,
    input wire logic i_uart_two_tx_empty,
    input wire logic i_uart_two_rx_full,
    input wire logic i_audio_serial_source,
    // Processor requests, active low, plus a combined level.
    output logic o_fast_interrupt_request_n,
    output logic o_normal_interrupt_request_n,
    output logic o_any_request
);

    // ------------------------------------------------------------
    // Byte-lane helper
    // ------------------------------------------------------------
    // Expands the two low byte enables into a 16-bit write mask.
    function automatic logic [15:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    // Reset asserts at once and releases two edges later, free of races.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Source assembly
    // ------------------------------------------------------------
    wire logic [15:0] raw_first; // RQ1
    wire logic [15:0] raw_second;
    wire logic raw_third;

    // Pins are inverted so that every bit is high while requesting.
    assign raw_first[SIC_BIT_EXT_FAST] = ~i_external_fast_pin_n; // RQ11
    assign raw_first[SIC_BIT_BATTERY_LOW] = i_battery_low_source; // RQ11
    assign raw_first[SIC_BIT_WATCHDOG] = i_watchdog_expired_source; // RQ11
    assign raw_first[SIC_BIT_MEDIA] = i_media_changed_source; // RQ11
    assign raw_first[SIC_BIT_CODEC] = i_codec_sound_source; // RQ12
    assign raw_first[SIC_BIT_EXT_ONE] = ~i_external_pin_one_n; // RQ12
    assign raw_first[SIC_BIT_EXT_TWO] = ~i_external_pin_two_n; // RQ12
    assign raw_first[SIC_BIT_EXT_THREE] = i_external_source_three; // RQ12
    assign raw_first[SIC_BIT_TIMER_ONE] = i_timer_one_underflow; // RQ13
    assign raw_first[SIC_BIT_TIMER_TWO] = i_timer_two_underflow; // RQ13
    assign raw_first[SIC_BIT_CLOCK_MATCH] = i_clock_compare_match; // RQ13
    assign raw_first[SIC_BIT_TICK] = i_periodic_tick_source; // RQ13
    assign raw_first[SIC_BIT_U1_TX] = i_uart_one_tx_empty; // RQ14
    assign raw_first[SIC_BIT_U1_RX] = i_uart_one_rx_full; // RQ14
    assign raw_first[SIC_BIT_U1_MODEM] = i_uart_one_modem_change; // RQ14
    assign raw_first[SIC_BIT_SER1_DONE] = i_serial_one_transfer_done; // RQ14

    // Unallocated second-pair positions are tied low and never request.
    assign raw_second = SIC_USED_SECOND & ( // RQ15
        (16'(i_key_press_source) << SIC_BIT_KEY)
        | (16'(i_serial_two_rx_block) << SIC_BIT_SER2_RX)
        | (16'(i_serial_two_tx_block) << SIC_BIT_SER2_TX)
        | (16'(i_uart_two_tx_empty) << SIC_BIT_U2_TX)
        | (16'(i_uart_two_rx_full) << SIC_BIT_U2_RX)); // RQ17

    assign raw_third = i_audio_serial_source; // RQ16

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [15:0] mask_first_reg;
    logic [15:0] mask_second_reg;
    logic mask_third_reg;
    logic [15:0] status_first_reg;
    logic [15:0] status_second_reg;
    logic status_third_reg;
    logic [15:0] latch_reg;

    // A request is taken once; ack blocks a second take in the next cycle.
    wire logic bus_take = i_wb_cyc & i_wb_stb & ~ack_reg;
    // Writes land at the ack edge, while the master still holds the request.
    wire logic bus_commit = i_wb_cyc & i_wb_stb & ack_reg;
    wire logic bus_write = bus_commit & i_wb_we;
    wire logic [15:0] lanes = lane_mask(i_wb_sel);
    wire logic wr_mask_first = bus_write & (i_wb_adr == SIC_OFS_MASK_FIRST);
    wire logic wr_mask_second = bus_write & (i_wb_adr == SIC_OFS_MASK_SECOND);
    wire logic wr_mask_third = bus_write & (i_wb_adr == SIC_OFS_MASK_THIRD) & i_wb_sel[0];
    wire logic wr_clear = bus_write & (i_wb_adr == SIC_OFS_LATCH_CLEAR);
    wire logic [15:0] clear_bits = wr_clear ? (i_wb_dat[15:0] & lanes & SIC_LATCHED_FIRST) : 16'h0000;

    // Unmapped and write-only addresses read as zero; writes to unmapped and status addresses are ignored.
    wire logic [31:0] read_word =
        (i_wb_adr == SIC_OFS_STATUS_FIRST) ? {16'h0000, status_first_reg} : // RQ7
        (i_wb_adr == SIC_OFS_MASK_FIRST) ? {16'h0000, mask_first_reg} :
        (i_wb_adr == SIC_OFS_STATUS_SECOND) ? {16'h0000, status_second_reg} : // RQ7
        (i_wb_adr == SIC_OFS_MASK_SECOND) ? {16'h0000, mask_second_reg} :
        (i_wb_adr == SIC_OFS_STATUS_THIRD) ? {31'h0000_0000, status_third_reg} : // RQ7
        (i_wb_adr == SIC_OFS_MASK_THIRD) ? {31'h0000_0000, mask_third_reg} :
        SIC_RST_WORD;

    // Ack follows the take by one edge and lasts one cycle.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= SIC_RST_WORD;
        end else begin
            ack_reg <= bus_take;
            rdata_reg <= (bus_take & ~i_wb_we) ? read_word : SIC_RST_WORD;
        end
    end

    // ------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------
    wire logic [15:0] mask_first_next = wr_mask_first ?
        ((mask_first_reg & ~lanes) | (i_wb_dat[15:0] & lanes)) : mask_first_reg;
    wire logic [15:0] mask_second_next = wr_mask_second ?
        ((mask_second_reg & ~lanes) | (i_wb_dat[15:0] & lanes & SIC_USED_SECOND)) : mask_second_reg;
    wire logic mask_third_next = wr_mask_third ? i_wb_dat[0] : mask_third_reg;

    // Masks start closed so nothing reaches the processor before software opens them.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_first_reg <= SIC_RST_MASK; // RQ18
            mask_second_reg <= SIC_RST_MASK; // RQ18
            mask_third_reg <= 1'b0; // RQ18
        end else begin
            mask_first_reg <= mask_first_next;
            mask_second_reg <= mask_second_next;
            mask_third_reg <= mask_third_next;
        end
    end

    // ------------------------------------------------------------
    // Status and latching
    // ------------------------------------------------------------
    // A latched source stays set until cleared; a new request in the clearing
    // cycle wins, so an event arriving then is never lost.
    wire logic [15:0] latch_next = (latch_reg & ~clear_bits) | (raw_first & SIC_LATCHED_FIRST); // RQ9
    // Unlatched bits simply follow their source; the source must hold on. // RQ10
    wire logic [15:0] status_first_next = (raw_first & ~SIC_LATCHED_FIRST) | latch_next; // RQ5

    // Status is sampled every edge, so it tracks levels, not edges.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= SIC_RST_STATUS;
            status_first_reg <= SIC_RST_STATUS;
            status_second_reg <= SIC_RST_STATUS;
            status_third_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next; // RQ9
            status_first_reg <= status_first_next; // RQ5
            status_second_reg <= raw_second; // RQ5
            status_third_reg <= raw_third; // RQ5
        end
    end

    // ------------------------------------------------------------
    // Request outputs
    // ------------------------------------------------------------
    // Each group is a flat OR with no arbitration inside it; the dispatch code
    // reads status and chooses the order itself.
    wire logic [15:0] enabled_first = status_first_reg & mask_first_reg; // RQ6
    wire logic [15:0] enabled_second = status_second_reg & mask_second_reg; // RQ6
    wire logic enabled_third = status_third_reg & mask_third_reg; // RQ6
    wire logic fast_pending = |(enabled_first & SIC_FAST_FIRST) | enabled_third; // RQ2 RQ16 RQ17 RQ4
    wire logic normal_pending = |(enabled_first & ~SIC_FAST_FIRST) | |enabled_second; // RQ2 RQ17 RQ4

    logic fast_n_reg;
    logic normal_n_reg;
    logic any_reg;

    // Both outputs share the same single-stage path so the fast request is never
    // later than the normal one; the processor ranks fast above normal.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_n_reg <= 1'b1;
            normal_n_reg <= 1'b1;
            any_reg <= 1'b0;
        end else begin
            fast_n_reg <= ~fast_pending; // RQ3
            normal_n_reg <= ~normal_pending;
            any_reg <= fast_pending | normal_pending;
        end
    end

    assign o_fast_interrupt_request_n = fast_n_reg;
    assign o_normal_interrupt_request_n = normal_n_reg;
    assign o_any_request = any_reg;
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdata_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking sic_cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n);

    fast_drive_a: assert property (fast_pending |=> !o_fast_interrupt_request_n) // RQ2
        else $error("Fast request missing for an enabled fast source.");

    normal_drive_a: assert property (normal_pending |=> !o_normal_interrupt_request_n) // RQ17
        else $error("Normal request missing for an enabled normal source.");

    mask_gate_a: assert property ((enabled_first == 16'h0000) && !enabled_third && // RQ6
        (enabled_second == 16'h0000) |=>
        o_fast_interrupt_request_n && o_normal_interrupt_request_n)
        else $error("Request raised with every source masked off.");

    fast_group_a: assert property ( // RQ11
        !i_external_fast_pin_n ##1 mask_first_reg[SIC_BIT_EXT_FAST] |=> !o_fast_interrupt_request_n)
        else $error("External fast pin did not reach the fast request in two edges.");

    level_follow_a: assert property ( // RQ5
        (status_first_reg & ~SIC_LATCHED_FIRST) == ($past(raw_first) & ~SIC_LATCHED_FIRST))
        else $error("Unlatched status bit does not follow its source level.");

    latch_hold_a: assert property ((latch_reg != 16'h0000) && !wr_clear |=> // RQ9
        ((latch_reg & $past(latch_reg)) == $past(latch_reg)))
        else $error("Latched source dropped without a clear write.");

    unused_zero_a: assert property ((status_second_reg & ~SIC_USED_SECOND) == 16'h0000) // RQ17
        else $error("Unallocated second-pair bit is set.");

    mask_reset_a: assert property ($rose(rst_n) |-> // RQ18
        (mask_first_reg == SIC_RST_MASK) && (mask_second_reg == SIC_RST_MASK) && !mask_third_reg)
        else $error("Mask bits not zero after reset.");

    status_read_a: assert property (bus_take && !i_wb_we && (i_wb_adr == SIC_OFS_STATUS_SECOND) |=> // RQ7
        o_wb_ack && (o_wb_dat == {16'h0000, $past(status_second_reg)}))
        else $error("Status read returned the wrong word.");

    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("Ack held longer than one cycle.");

    // Request outputs against the enabled groups.
    any_on_a: assert property ( // RQ17
        fast_pending || normal_pending
        |=> o_any_request)
        else $error("Combined level missing.");

    any_off_a: assert property ( // RQ6
        !fast_pending && !normal_pending
        |=> !o_any_request)
        else $error("Combined level without a source.");

    fast_only_a: assert property ( // RQ2
        !fast_pending
        |=> o_fast_interrupt_request_n)
        else $error("Fast request without a fast source.");

    normal_only_a: assert property ( // RQ2
        !normal_pending
        |=> o_normal_interrupt_request_n)
        else $error("Normal request without a normal source.");

    audio_fast_a: assert property ( // RQ16
        enabled_third
        |=> !o_fast_interrupt_request_n)
        else $error("Audio source missed the fast request.");

    // Status and latch behaviour.
    set_wins_a: assert property ( // RQ9
        raw_first[SIC_BIT_TIMER_ONE]
        |=> latch_reg[SIC_BIT_TIMER_ONE])
        else $error("Timer event lost in the latch.");

    latch_clear_a: assert property ( // RQ9
        clear_bits[SIC_BIT_TICK] && !raw_first[SIC_BIT_TICK]
        |=> !latch_reg[SIC_BIT_TICK])
        else $error("Tick latch survived its clear.");

    second_follow_a: assert property ( // RQ5
        status_second_reg
        == $past(raw_second))
        else $error("Second-pair status off its sources.");

    third_follow_a: assert property ( // RQ5
        status_third_reg
        == $past(raw_third))
        else $error("Third-pair status off its source.");

    pin_one_a: assert property ( // RQ12
        !i_external_pin_one_n
        |=> status_first_reg[SIC_BIT_EXT_ONE])
        else $error("External pin one not in status.");

    key_map_a: assert property ( // RQ15
        i_key_press_source
        |=> status_second_reg[SIC_BIT_KEY])
        else $error("Key press not in status.");

    // Register bus and mask storage.
    mask_unused_a: assert property ( // RQ17
        (mask_second_reg & ~SIC_USED_SECOND)
        == 16'h0000)
        else $error("Unallocated mask bit set.");

    mask_hold_a: assert property ( // RQ6
        !bus_write
        |=> $stable(mask_first_reg) && $stable(mask_second_reg) && $stable(mask_third_reg))
        else $error("Mask changed without a write.");

    read_idle_a: assert property ( // RQ7
        !o_wb_ack
        |-> (o_wb_dat == SIC_RST_WORD))
        else $error("Read data outside the answer cycle.");

endmodule

// >>> sic_pkg.sv
// Shared constants for the interrupt controller: register map, field layout and reset values.
package sic_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the bus
    // ------------------------------------------------------------
    localparam logic [7:0] SIC_OFS_STATUS_FIRST = 8'h00;
    localparam logic [7:0] SIC_OFS_MASK_FIRST = 8'h04;
    localparam logic [7:0] SIC_OFS_STATUS_SECOND = 8'h08;
    localparam logic [7:0] SIC_OFS_MASK_SECOND = 8'h0C;
    localparam logic [7:0] SIC_OFS_STATUS_THIRD = 8'h10;
    localparam logic [7:0] SIC_OFS_MASK_THIRD = 8'h14;
    localparam logic [7:0] SIC_OFS_LATCH_CLEAR = 8'h18;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    // Source counts per group.
    localparam int SIC_SOURCE_COUNT = 22;
    localparam int SIC_NORMAL_COUNT = 17;
    localparam int SIC_FAST_COUNT = 5;
    // Bit positions in the first pair.
    localparam int SIC_BIT_EXT_FAST = 0;
    localparam int SIC_BIT_BATTERY_LOW = 1;
    localparam int SIC_BIT_WATCHDOG = 2;
    localparam int SIC_BIT_MEDIA = 3;
    localparam int SIC_BIT_CODEC = 4;
    localparam int SIC_BIT_EXT_ONE = 5;
    localparam int SIC_BIT_EXT_TWO = 6;
    localparam int SIC_BIT_EXT_THREE = 7;
    localparam int SIC_BIT_TIMER_ONE = 8;
    localparam int SIC_BIT_TIMER_TWO = 9;
    localparam int SIC_BIT_CLOCK_MATCH = 10;
    localparam int SIC_BIT_TICK = 11;
    localparam int SIC_BIT_U1_TX = 12;
    localparam int SIC_BIT_U1_RX = 13;
    localparam int SIC_BIT_U1_MODEM = 14;
    localparam int SIC_BIT_SER1_DONE = 15;
    // Bit positions in the second pair.
    localparam int SIC_BIT_KEY = 0;
    localparam int SIC_BIT_SER2_RX = 1;
    localparam int SIC_BIT_SER2_TX = 2;
    localparam int SIC_BIT_U2_TX = 12;
    localparam int SIC_BIT_U2_RX = 13;
    // Bit position in the third pair.
    localparam int SIC_BIT_AUDIO = 0;
    // Allocated bits of the first two pairs and fast-group bits of the first pair.
    localparam logic [15:0] SIC_USED_FIRST = 16'hFFFF;
    localparam logic [15:0] SIC_USED_SECOND = 16'h3007;
    localparam logic [15:0] SIC_FAST_FIRST = 16'h000F;
    // First-pair sources that are latched until cleared.
    localparam logic [15:0] SIC_LATCHED_FIRST = 16'h8F00;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SIC_RST_MASK = 16'h0000;
    localparam logic [15:0] SIC_RST_STATUS = 16'h0000;
    localparam logic [31:0] SIC_RST_WORD = 32'h0000_0000;

endpackage

// >>> sic_cpu_model.sv
// Processor-side model: turns the two active-low request levels into the exception the core takes.
`timescale 1ns/1ps

module sic_cpu_model (
    // Request levels from the controller.
    input wire logic i_fast_n,
    input wire logic i_normal_n,
    // Taken exception: bit 0 fast, bit 1 normal.
    output logic [1:0] o_taken
);
    // The core sees only the group, so the handler picks the order inside a group.
    // A low fast level always wins, and a pending normal request waits behind it.
    assign o_taken[0] = ~i_fast_n;
    assign o_taken[1] = ~i_normal_n & i_fast_n;
endmodule

// >>> test_sic_top.sv
// Self-checking bench for the interrupt controller against a behavioural model and a processor model.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); end end

module test_sic_top;
    import sic_pkg::*;

    // ------------------------------------------------------------
    // Stimulus, model state and instances
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_rstn = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic [15:0] src1 = 16'h0000;
    logic [15:0] src2 = 16'h0000;
    logic src3 = 1'b0;
    logic fast_n;
    logic normal_n;
    logic any_req;
    logic [1:0] taken;
    logic [15:0] m1, m2, lat;
    logic m3;
    logic [31:0] seed = 32'h0000_4ffb;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int pos2 [5] = '{0, 1, 2, 12, 13};

    // Pins other than the third input are active low, so the bench keeps sources active high and inverts at those pins.
    sic_top u_dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
        .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
        .i_external_fast_pin_n(~src1[0]), .i_battery_low_source(src1[1]), .i_watchdog_expired_source(src1[2]),
        .i_media_changed_source(src1[3]), .i_codec_sound_source(src1[4]), .i_external_pin_one_n(~src1[5]),
        .i_external_pin_two_n(~src1[6]), .i_external_source_three(src1[7]), .i_timer_one_underflow(src1[8]),
        .i_timer_two_underflow(src1[9]), .i_clock_compare_match(src1[10]), .i_periodic_tick_source(src1[11]),
        .i_uart_one_tx_empty(src1[12]), .i_uart_one_rx_full(src1[13]), .i_uart_one_modem_change(src1[14]),
        .i_serial_one_transfer_done(src1[15]), .i_key_press_source(src2[0]), .i_serial_two_rx_block(src2[1]),
        .i_serial_two_tx_block(src2[2]), .i_uart_two_tx_empty(src2[12]), .i_uart_two_rx_full(src2[13]),
        .i_audio_serial_source(src3), .o_fast_interrupt_request_n(fast_n),
        .o_normal_interrupt_request_n(normal_n), .o_any_request(any_req)
    );
    sic_cpu_model u_cpu (.i_fast_n(fast_n), .i_normal_n(normal_n), .o_taken(taken));

    // Free-running 40 MHz clock.
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // Model, bus and check tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] st1();
        return (src1 & ~SIC_LATCHED_FIRST) | lat;
    endfunction
    function automatic logic exp_fast();
        return (|(st1() & m1 & SIC_FAST_FIRST)) | (src3 & m3);
    endfunction
    function automatic logic exp_norm();
        return (|(st1() & m1 & ~SIC_FAST_FIRST)) | (|(src2 & m2 & SIC_USED_SECOND));
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One classic cycle; the request stands until ack is sampled high at a rising edge.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                      output logic [31:0] rd);
        int n = 0;
        @(posedge i_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        wb_sel <= sel;
        do begin
            @(posedge i_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 50) `CHK("bus answer", 1'b1, wb_ack)
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0000_0000, 4'hF, r);
        `CHK(what, exp, r)
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        wb(1'b1, adr, dat, sel, r);
    endtask

    // Status read-back and request pins against the model.
    task automatic check_all();
        rd_chk(SIC_OFS_STATUS_FIRST, {16'h0000, st1()}, "status first");
        rd_chk(SIC_OFS_STATUS_SECOND, {16'h0000, src2 & SIC_USED_SECOND}, "status second");
        rd_chk(SIC_OFS_STATUS_THIRD, {31'h0000_0000, src3}, "status third");
        #1;
        `CHK("fast request", ~exp_fast(), fast_n)
        `CHK("normal request", ~exp_norm(), normal_n)
        `CHK("any request", exp_fast() | exp_norm(), any_req)
        `CHK("taken", {exp_norm() & ~exp_fast(), exp_fast()}, taken)
    endtask
    task automatic set_src(input logic [15:0] s1, input logic [15:0] s2, input logic s3);
        @(posedge i_clk);
        src1 <= s1;
        src2 <= s2;
        src3 <= s3;
        lat = lat | (s1 & SIC_LATCHED_FIRST);
        repeat (2) @(posedge i_clk);
    endtask
    task automatic clear(input logic [15:0] c);
        wr(SIC_OFS_LATCH_CLEAR, {16'h0000, c}, 4'b0011);
        lat = (lat & ~c) | (src1 & SIC_LATCHED_FIRST);
    endtask
    task automatic set_masks(input logic [15:0] a, input logic [15:0] b, input logic c);
        wr(SIC_OFS_MASK_FIRST, {16'h0000, a}, 4'b0011);
        wr(SIC_OFS_MASK_SECOND, {16'h0000, b}, 4'b0011);
        wr(SIC_OFS_MASK_THIRD, {31'h0000_0000, c}, 4'b0001);
        m1 = a;
        m2 = b & SIC_USED_SECOND;
        m3 = c;
        rd_chk(SIC_OFS_MASK_FIRST, {16'h0000, m1}, "mask first");
        rd_chk(SIC_OFS_MASK_SECOND, {16'h0000, m2}, "mask second");
        rd_chk(SIC_OFS_MASK_THIRD, {31'h0000_0000, m3}, "mask third");
    endtask
    task automatic do_reset();
        src1 <= 16'h0000;
        src2 <= 16'h0000;
        src3 <= 1'b0;
        i_rstn <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        m1 = 16'h0000;
        m2 = 16'h0000;
        m3 = 1'b0;
        lat = 16'h0000;
        repeat (3) @(posedge i_clk);
        rd_chk(SIC_OFS_MASK_FIRST, SIC_RST_WORD, "mask first reset");
        rd_chk(SIC_OFS_MASK_SECOND, SIC_RST_WORD, "mask second reset");
        rd_chk(SIC_OFS_MASK_THIRD, SIC_RST_WORD, "mask third reset");
        rd_chk(SIC_OFS_LATCH_CLEAR, SIC_RST_WORD, "clear register");
        rd_chk(8'h1C, SIC_RST_WORD, "unmapped");
        check_all();
    endtask

    // A hang is cut short well beyond the few thousand cycles the run needs.
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        int i;
        logic [31:0] r;
        logic [15:0] s1, s2;
        do_reset();
        $display("test reset done");
        wr(SIC_OFS_MASK_FIRST, 32'h0000_FFFF, 4'b0001);
        rd_chk(SIC_OFS_MASK_FIRST, 32'h0000_00FF, "mask byte lane");
        set_masks(16'hFFFF, 16'hFFFF, 1'b1);
        // Each source alone: two edges from source to pin, right group, latch kept after it drops.
        for (i = 0; i < SIC_SOURCE_COUNT; i++) begin
            s1 = 16'h0000;
            s2 = 16'h0000;
            if (i < 16) s1[i] = 1'b1;
            else if (i < 21) s2[pos2[i - 16]] = 1'b1;
            @(posedge i_clk);
            src1 <= s1;
            src2 <= s2;
            src3 <= (i == 21);
            lat = lat | (s1 & SIC_LATCHED_FIRST);
            @(posedge i_clk);
            #1;
            `CHK("request after one edge", 2'b11, {fast_n, normal_n})
            @(posedge i_clk);
            #1;
            `CHK("fast group", (i < 4 || i == 21) ? 1'b0 : 1'b1, fast_n)
            check_all();
            set_src(16'h0000, 16'h0000, 1'b0);
            check_all();
            clear(16'hFFFF);
        end
        $display("test single sources done");
        // Random masks and sources; status writes must be ignored and set wins over clear.
        for (i = 0; i < 30; i++) begin
            r = xorshift();
            set_masks(r[15:0], r[31:16], r[7]);
            r = xorshift();
            wr(SIC_OFS_STATUS_FIRST, r, 4'b0011);
            set_src(r[15:0], r[31:16], r[3]);
            check_all();
            r = xorshift();
            clear(r[15:0]);
            check_all();
        end
        $display("test random sources done");
        @(posedge i_clk);
        do_reset();
        $display("test second reset done");
        finish_test();
    end
endmodule
